// file: pkg/osc_pkg.sv
// What this block does
// - Source-rate clock plus half-rate divided clock.
// - Reset always selects the internal oscillator.
// - Internal oscillator nominally 12.8 MHz source.
// - Eight-bit trim; larger value, longer period.
// - Reset loads trim with midpoint 80h.
// - External select claims input pin, crystal output.
// - Two external rising edges before switching.
// - Switch without glitch or runt pulse.
// - Set engaged status, then stop internal.
// - Internal restarts only on reset.
// - Crystal: output pin is amplifier only.
// - Direct clock: output pin is port bit.
// - Internal/RC: enable selects clock or port.
// - Select codes: internal, external, RC, crystal.
// - Reset clears the external request bit.
// - Stop halts both clocks; wait keeps them.
package osc_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] STATUS_OFFSET = 8'h36;
  localparam logic [7:0] TRIM_OFFSET   = 8'h38;
  localparam logic [7:0] CONFIG_OFFSET = 8'h3A;

  // Field positions.
  localparam int STATUS_ENGAGED_BIT = 0;
  localparam int STATUS_REQUEST_BIT = 1;
  localparam int CONFIG_SELECT_LSB  = 0;
  localparam int CONFIG_PIN_EN_BIT  = 2;

  // Reset values.
  localparam logic [7:0] TRIM_RESET   = 8'h80;
  localparam logic [1:0] SELECT_RESET = 2'h0;

  // Activity edges awaited before the swap.
  localparam logic [1:0] ACTIVITY_EDGES = 2'h2;

  // Nominal internal rate and the system clock rate, in kHz.
  localparam int INT_OSC_KHZ = 12800;
  localparam int SYS_CLK_KHZ = 40000;
  // Half period of the modelled internal clock at zero trim, rounded down, at least one cycle.
  localparam int INT_HALF_CYCLES_RAW = SYS_CLK_KHZ / (2 * INT_OSC_KHZ);
  localparam int INT_HALF_CYCLES     = (INT_HALF_CYCLES_RAW < 1) ? 1 : INT_HALF_CYCLES_RAW;

  // Clock source encodings.
  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'h0,
    SRC_EXTERNAL = 2'h1,
    SRC_RC       = 2'h2,
    SRC_CRYSTAL  = 2'h3
  } clock_source_t;

  // Switch sequence, Gray coded along the path.
  typedef enum logic [2:0] {
    SW_INTERNAL = 3'h0,
    SW_ARMED    = 3'h1,
    SW_EDGE_ONE = 3'h3,
    SW_SWAP     = 3'h2,
    SW_ENGAGED  = 3'h6
  } switch_state_t;

endpackage : osc_pkg

// file: core/internal_osc_model.sv
`timescale 1ns/1ps
// Digital stand-in for the trimmable internal oscillator: a level that toggles at a trim-dependent period.
module internal_osc_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic       i_run,
  input  wire logic [7:0] i_trim,
  output logic            o_level
);

  logic [9:0] count_ff;
  logic [9:0] nxt_count;
  logic       level_ff;
  logic       nxt_level;
  logic [9:0] half_limit;

  // Each 32-step rise of the trim, from zero up, lengthens the half period by one cycle; the step is coarse in this model.
  always_comb begin
    half_limit = 10'(osc_pkg::INT_HALF_CYCLES) + 10'(i_trim[7:5]);
    nxt_count  = count_ff;
    nxt_level  = level_ff;
    if (!i_run) begin
      nxt_count = 10'h000;
      nxt_level = 1'b0;
    end else if (count_ff + 10'h001 >= half_limit) begin
      nxt_count = 10'h000;
      nxt_level = ~level_ff;
    end else begin
      nxt_count = count_ff + 10'h001;
    end
  end

  // State registers.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      count_ff <= 10'h000;
      level_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      level_ff <= nxt_level;
    end
  end

  assign o_level = level_ff;

endmodule : internal_osc_model

// file: core/osc_clock_source_switch.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ps
// Clock source selection, glitch-free internal to external switch, and clock-out pin steering.
module osc_clock_source_switch (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  output logic      [7:0] o_rd_data,
  input  wire logic       i_stop_mode,
  input  wire logic       i_clock_in_pin,
  input  wire logic       i_port_a_bit_four_o,
  input  wire logic       i_port_a_bit_four_oe_n,
  output logic            o_clock_out_pin_o,
  output logic            o_clock_out_pin_oe_n,
  output logic            o_clock_in_pin_is_clock,
  output logic            o_source_rate_clock,
  output logic            o_half_rate_clock,
  output logic            o_internal_osc_running
);

  // Pin synchroniser: the first stage feeds only the second.
  logic       pin_meta_ff;
  logic       pin_sync_ff;
  logic       pin_prev_ff;

  // Registers.
  logic [7:0] trim_ff;
  logic [7:0] nxt_trim;
  logic [1:0] select_ff;
  logic [1:0] nxt_select;
  logic       pin_en_ff;
  logic       nxt_pin_en;
  logic       request_ff;
  logic       nxt_request;
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;

  // Switch sequence state.
  osc_pkg::switch_state_t state_ff;
  osc_pkg::switch_state_t nxt_state;
  logic [1:0] edge_count_ff;
  logic [1:0] nxt_edge_count;
  logic       use_ext_ff;
  logic       nxt_use_ext;
  logic       engaged_ff;
  logic       nxt_engaged;
  logic       int_run_ff;
  logic       nxt_int_run;

  // Output clocks.
  logic       src_ff;
  logic       nxt_src;
  logic       half_ff;
  logic       nxt_half;
  logic       pin_o_ff;
  logic       nxt_pin_o;
  logic       pin_oe_n_ff;
  logic       nxt_pin_oe_n;

  logic       int_level;
  logic       ext_rise;
  logic       mux_level;

  // The internal oscillator runs until the external source has been engaged.
  internal_osc_model u_int_osc (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_run     (int_run_ff),
    .i_trim    (trim_ff),
    .o_level   (int_level)
  );

  // Two flip-flops before any logic sees the pin.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
      pin_prev_ff <= 1'b0;
    end else begin
      pin_meta_ff <= i_clock_in_pin;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  assign ext_rise = pin_sync_ff & ~pin_prev_ff;

  // Register writes and the read path; unmapped addresses read as zero.
  always_comb begin
    nxt_trim    = trim_ff;
    nxt_select  = select_ff;
    nxt_pin_en  = pin_en_ff;
    nxt_request = request_ff;
    nxt_rd_data = 8'h00;
    if (i_wr_en) begin
      unique case (i_addr)
        osc_pkg::TRIM_OFFSET: begin
          nxt_trim = i_wr_data;
        end
        osc_pkg::STATUS_OFFSET: begin
          nxt_request = i_wr_data[osc_pkg::STATUS_REQUEST_BIT];
        end
        osc_pkg::CONFIG_OFFSET: begin
          nxt_select = i_wr_data[osc_pkg::CONFIG_SELECT_LSB +: 2];
          nxt_pin_en = i_wr_data[osc_pkg::CONFIG_PIN_EN_BIT];
        end
        default: begin
          nxt_trim = trim_ff;
        end
      endcase
    end
    if (i_rd_en) begin
      unique case (i_addr)
        osc_pkg::TRIM_OFFSET: begin
          nxt_rd_data = trim_ff;
        end
        osc_pkg::STATUS_OFFSET: begin
          nxt_rd_data[osc_pkg::STATUS_REQUEST_BIT] = request_ff;
          nxt_rd_data[osc_pkg::STATUS_ENGAGED_BIT] = engaged_ff;
        end
        osc_pkg::CONFIG_OFFSET: begin
          nxt_rd_data[osc_pkg::CONFIG_SELECT_LSB +: 2] = select_ff;
          nxt_rd_data[osc_pkg::CONFIG_PIN_EN_BIT]      = pin_en_ff;
        end
        default: begin
          nxt_rd_data = 8'h00;
        end
      endcase
    end
  end

  // Register state; reset restores the midpoint trim, the internal source and a low request.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      trim_ff    <= osc_pkg::TRIM_RESET;
      select_ff  <= osc_pkg::SELECT_RESET;
      pin_en_ff  <= 1'b0;
      request_ff <= 1'b0;
      rd_data_ff <= 8'h00;
    end else begin
      trim_ff    <= nxt_trim;
      select_ff  <= nxt_select;
      pin_en_ff  <= nxt_pin_en;
      request_ff <= nxt_request;
      rd_data_ff <= nxt_rd_data;
    end
  end

  // Switch sequence. The request is only honoured with an external source chosen, and the path
  // is one-way: nothing but reset brings the internal oscillator back, even if the pin dies.
  always_comb begin
    nxt_state      = state_ff;
    nxt_edge_count = edge_count_ff;
    nxt_use_ext    = use_ext_ff;
    nxt_engaged    = engaged_ff;
    nxt_int_run    = int_run_ff;
    unique case (state_ff)
      osc_pkg::SW_INTERNAL: begin
        nxt_edge_count = 2'h0;
        if (request_ff && (select_ff != osc_pkg::SRC_INTERNAL)) begin
          nxt_state = osc_pkg::SW_ARMED;
        end
      end
      osc_pkg::SW_ARMED: begin
        if (ext_rise) begin
          nxt_edge_count = edge_count_ff + 2'h1;
          nxt_state      = osc_pkg::SW_EDGE_ONE;
        end
      end
      osc_pkg::SW_EDGE_ONE: begin
        if (ext_rise) begin
          nxt_edge_count = edge_count_ff + 2'h1;
        end
        if (edge_count_ff == osc_pkg::ACTIVITY_EDGES) begin
          nxt_state = osc_pkg::SW_SWAP;
        end
      end
      osc_pkg::SW_SWAP: begin
        // Moving the mux only while both sources are low leaves no runt on either output.
        if (!int_level && !pin_sync_ff) begin
          nxt_use_ext = 1'b1;
          nxt_engaged = 1'b1;
          nxt_state   = osc_pkg::SW_ENGAGED;
        end
      end
      osc_pkg::SW_ENGAGED: begin
        nxt_int_run = 1'b0;
      end
      default: begin
        nxt_state = osc_pkg::SW_INTERNAL;
      end
    endcase
  end

  // Switch state registers.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_ff      <= osc_pkg::SW_INTERNAL;
      edge_count_ff <= 2'h0;
      use_ext_ff    <= 1'b0;
      engaged_ff    <= 1'b0;
      int_run_ff    <= 1'b1;
    end else begin
      state_ff      <= nxt_state;
      edge_count_ff <= nxt_edge_count;
      use_ext_ff    <= nxt_use_ext;
      engaged_ff    <= nxt_engaged;
      int_run_ff    <= nxt_int_run;
    end
  end

  assign mux_level = use_ext_ff ? pin_sync_ff : int_level;

  // Derived clocks; stop mode holds both low, wait mode has no effect on them.
  always_comb begin
    nxt_src  = mux_level;
    nxt_half = half_ff;
    if (i_stop_mode) begin
      nxt_src  = 1'b0;
      nxt_half = 1'b0;
    end else if (mux_level && !src_ff) begin
      nxt_half = ~half_ff;
    end
  end

  // Clock-out pin steering by source; the port bit passes through when the pin is free.
  always_comb begin
    nxt_pin_o    = i_port_a_bit_four_o;
    nxt_pin_oe_n = i_port_a_bit_four_oe_n;
    unique case (osc_pkg::clock_source_t'(select_ff))
      osc_pkg::SRC_CRYSTAL: begin
        nxt_pin_o    = ~pin_sync_ff;
        nxt_pin_oe_n = 1'b0;
      end
      osc_pkg::SRC_EXTERNAL: begin
        nxt_pin_o    = i_port_a_bit_four_o;
        nxt_pin_oe_n = i_port_a_bit_four_oe_n;
      end
      osc_pkg::SRC_INTERNAL, osc_pkg::SRC_RC: begin
        if (pin_en_ff) begin
          nxt_pin_o    = nxt_src;
          nxt_pin_oe_n = 1'b0;
        end
      end
    endcase
  end

  // Output registers.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      src_ff      <= 1'b0;
      half_ff     <= 1'b0;
      pin_o_ff    <= 1'b0;
      pin_oe_n_ff <= 1'b1;
    end else begin
      src_ff      <= nxt_src;
      half_ff     <= nxt_half;
      pin_o_ff    <= nxt_pin_o;
      pin_oe_n_ff <= nxt_pin_oe_n;
    end
  end

  assign o_rd_data               = rd_data_ff;
  assign o_source_rate_clock     = src_ff;
  assign o_half_rate_clock       = half_ff;
  assign o_clock_out_pin_o       = pin_o_ff;
  assign o_clock_out_pin_oe_n    = pin_oe_n_ff;
  assign o_clock_in_pin_is_clock = (select_ff != osc_pkg::SRC_INTERNAL);
  assign o_internal_osc_running  = int_run_ff;

endmodule : osc_clock_source_switch

// file: verif/osc_clock_source_switch_sva.sv
`timescale 1ns/1ps
// Port-level checks of the clock source block, with a shadow of the config register.
module osc_clock_source_switch_sva (
  input wire logic       i_sys_clk,
  input wire logic       i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic       i_wr_en,
  input wire logic       i_rd_en,
  input wire logic [7:0] o_rd_data,
  input wire logic       i_stop_mode,
  input wire logic       i_clock_in_pin,
  input wire logic       i_port_a_bit_four_o,
  input wire logic       i_port_a_bit_four_oe_n,
  input wire logic       o_clock_out_pin_o,
  input wire logic       o_clock_out_pin_oe_n,
  input wire logic       o_clock_in_pin_is_clock,
  input wire logic       o_source_rate_clock,
  input wire logic       o_half_rate_clock,
  input wire logic       o_internal_osc_running
);
  logic [2:0] cfg_ff, nxt_cfg;
  logic [1:0] edges_ff, nxt_edges;
  logic       pin_ff;
  wire logic  pass_c = cfg_ff[1:0] == 2'h1 || !(cfg_ff[0] || cfg_ff[2]);

  // Raw pin rises since the last status or config write; they lead the design's synchronised view.
  always_comb begin
    nxt_cfg   = (i_wr_en && i_addr == osc_pkg::CONFIG_OFFSET) ? i_wr_data[2:0] : cfg_ff;
    nxt_edges = (i_clock_in_pin && !pin_ff && edges_ff != 2'h3) ? edges_ff + 2'h1 : edges_ff;
    if (i_wr_en && (i_addr == osc_pkg::CONFIG_OFFSET || i_addr == osc_pkg::STATUS_OFFSET)) nxt_edges = 2'h0;
  end

  // The config shadow and edge count clear together with the design; the pin sample does not.
  always_ff @(posedge i_sys_clk) begin
    cfg_ff   <= i_reset ? 3'h0 : nxt_cfg;
    edges_ff <= i_reset ? 2'h0 : nxt_edges;
    pin_ff   <= i_clock_in_pin;
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  sequence s_trim_wr; i_wr_en && i_addr == osc_pkg::TRIM_OFFSET; endsequence
  sequence s_trim_rd; i_rd_en && i_addr == osc_pkg::TRIM_OFFSET; endsequence
  property p_trim_rw; s_trim_wr ##1 s_trim_rd |=> o_rd_data == $past(i_wr_data, 2); endproperty
  property p_half; $rose(o_source_rate_clock) |-> ##[0:1] $changed(o_half_rate_clock); endproperty
  property p_stop; i_stop_mode |=> !o_source_rate_clock && !o_half_rate_clock; endproperty
  property p_osc_off; !o_internal_osc_running |=> !o_internal_osc_running; endproperty
  property p_is_clock;
    i_wr_en && i_addr == osc_pkg::CONFIG_OFFSET |=> o_clock_in_pin_is_clock == ($past(i_wr_data[1:0]) != 2'h0);
  endproperty
  property p_ext_pin;
    !$past(i_reset) && $past(pass_c) |-> o_clock_out_pin_o == $past(i_port_a_bit_four_o)
      && o_clock_out_pin_oe_n == $past(i_port_a_bit_four_oe_n);
  endproperty
  property p_drive_pin; !$past(i_reset) && !$past(pass_c) |-> !o_clock_out_pin_oe_n; endproperty
  property p_two_edges; $fell(o_internal_osc_running) |-> edges_ff >= 2'h2; endproperty

  a_trim_rw: assert property (p_trim_rw) else $error("trim read back differs");
  a_half: assert property (p_half) else $error("half-rate clock missed a toggle");
  a_stop: assert property (p_stop) else $error("clocks run in stop mode");
  a_osc_off: assert property (p_osc_off) else $error("internal oscillator restarted");
  a_is_clock: assert property (p_is_clock) else $error("input pin claim wrong");
  a_ext_pin: assert property (p_ext_pin) else $error("pin not passed to port");
  a_drive_pin: assert property (p_drive_pin) else $error("pin not driven");
  a_two_edges: assert property (p_two_edges) else $error("switch before two edges");
endmodule : osc_clock_source_switch_sva

bind osc_clock_source_switch osc_clock_source_switch_sva i_osc_clock_source_switch_sva (
  .i_sys_clk, .i_reset, .i_addr, .i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data, .i_stop_mode, .i_clock_in_pin,
  .i_port_a_bit_four_o, .i_port_a_bit_four_oe_n, .o_clock_out_pin_o, .o_clock_out_pin_oe_n,
  .o_clock_in_pin_is_clock, .o_source_rate_clock, .o_half_rate_clock, .o_internal_osc_running
);

// file: verif/ext_clock_source.sv
`timescale 1ns/1ps
// External clock source; its own time base keeps its phase unrelated to the system clock.
module ext_clock_source #(
  parameter int HALF_NS = 37
) (
  input  wire logic i_run,
  output logic      o_clk
);
  // A dead source holds the line low, as a stopped oscillator would.
  initial o_clk = 1'b0;
  always begin
    #HALF_NS;
    o_clk = i_run ? ~o_clk : 1'b0;
  end
endmodule : ext_clock_source

// file: verif/test_osc_clock_source_switch.sv
`timescale 1ns/1ps
// Bench for the clock source block; a watcher checks read data against values queued by the driver.
module test_osc_clock_source_switch;
  logic       i_sys_clk = 1'b0, i_reset = 1'b1, i_wr_en = 1'b0, i_rd_en = 1'b0, i_stop_mode = 1'b0;
  logic       i_port_a_bit_four_o = 1'b0, i_port_a_bit_four_oe_n = 1'b1;
  logic       ext_run = 1'b0, port_hold = 1'b0, rd_seen = 1'b0, ext_clk;
  logic [7:0] i_addr = 8'h00, i_wr_data = 8'h00, o_rd_data, rv;
  logic       o_clock_out_pin_o, o_clock_out_pin_oe_n, o_clock_in_pin_is_clock;
  logic       o_source_rate_clock, o_half_rate_clock, o_internal_osc_running;
  logic [7:0] exp_q[$];
  logic [7:0] trims[3] = '{8'h00, 8'h80, 8'hE0};
  int         miscompares = 0, n_checks = 0, cs, ch, h;

  osc_clock_source_switch i_osc_clock_source_switch (
    .i_sys_clk, .i_reset, .i_addr, .i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data, .i_stop_mode,
    .i_clock_in_pin(ext_clk), .i_port_a_bit_four_o, .i_port_a_bit_four_oe_n, .o_clock_out_pin_o,
    .o_clock_out_pin_oe_n, .o_clock_in_pin_is_clock, .o_source_rate_clock, .o_half_rate_clock,
    .o_internal_osc_running
  );
  ext_clock_source i_ext_clock_source (.i_run(ext_run), .o_clk(ext_clk));

  // The 40 MHz system clock.
  always #12.5 i_sys_clk = ~i_sys_clk;

  // Port logic wanders at random unless the crystal precharge holds the pin driven high.
  always @(posedge i_sys_clk) begin
    {i_port_a_bit_four_o, i_port_a_bit_four_oe_n} <= port_hold ? 2'h2 : 2'($urandom);
  end

  // Read data stand only in the cycle after the strobe, so they are taken at that cycle's falling edge.
  always @(negedge i_sys_clk) begin
    if (rd_seen) chk(o_rd_data, exp_q.pop_front());
    rd_seen = i_rd_en;
  end

  task automatic end_sim;
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // One bus cycle: op bit 1 writes, bit 0 reads; for a read d is the value expected back.
  task automatic bus(input logic [1:0] op, input logic [7:0] a, input logic [7:0] d);
    i_wr_en   <= op[1];
    i_rd_en   <= op[0];
    i_addr    <= a;
    i_wr_data <= d;
    if (op[0]) exp_q.push_back(d);
    @(posedge i_sys_clk);
  endtask : bus

  task automatic idle(input int n);
    repeat (n) bus(2'h0, 8'h00, 8'h00);
  endtask : idle

  // Counts level changes of both derived clocks over n cycles, sampled at falling edges.
  task automatic count(input int n);
    logic ps, ph;
    cs = 0;
    ch = 0;
    @(negedge i_sys_clk);
    repeat (n) begin
      ps = o_source_rate_clock;
      ph = o_half_rate_clock;
      @(negedge i_sys_clk);
      cs += int'(o_source_rate_clock !== ps);
      ch += int'(o_half_rate_clock !== ph);
    end
    @(posedge i_sys_clk);
  endtask : count

  // Reset, registers, clock rates, stop, pin steering, a refused request, the switch and a second reset.
  initial begin
    void'($urandom(42));
    repeat (5) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    @(posedge i_sys_clk);
    bus(2'h1, osc_pkg::TRIM_OFFSET, osc_pkg::TRIM_RESET);
    rv = 8'($urandom);
    bus(2'h2, osc_pkg::TRIM_OFFSET, rv);
    bus(2'h1, osc_pkg::TRIM_OFFSET, rv);
    bus(2'h1, osc_pkg::STATUS_OFFSET, 8'h00);
    bus(2'h2, 8'h50, 8'hFF);
    bus(2'h1, 8'h50, 8'h00);
    repeat (3) begin
      rv = 8'($urandom);
      bus(2'h2, osc_pkg::TRIM_OFFSET, rv);
      bus(2'h1, osc_pkg::TRIM_OFFSET, rv);
    end
    foreach (trims[k]) begin
      bus(2'h2, osc_pkg::TRIM_OFFSET, trims[k]);
      idle(20);
      count(240);
      h = 1 + int'(trims[k][7:5]);
      chk(8'(cs), 8'(240 / h));
      chk(8'(ch), 8'(120 / h));
    end
    i_stop_mode <= 1'b1;
    idle(2);
    count(20);
    chk(8'(cs + ch), 8'h00);
    i_stop_mode <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      bus(2'h2, osc_pkg::CONFIG_OFFSET, 8'(c));
      idle(3);
      @(negedge i_sys_clk);
      chk({7'h00, o_clock_in_pin_is_clock}, {7'h00, c[1:0] != 2'h0});
      if (c[1:0] == 2'h3 || c[2:0] == 3'h4 || c[2:0] == 3'h6) chk({7'h00, o_clock_out_pin_oe_n}, 8'h00);
      @(posedge i_sys_clk);
    end
    bus(2'h2, osc_pkg::CONFIG_OFFSET, 8'h00);
    ext_run <= 1'b1;
    bus(2'h2, osc_pkg::STATUS_OFFSET, 8'h02);
    idle(40);
    @(negedge i_sys_clk);
    chk({7'h00, o_internal_osc_running}, 8'h01);
    @(posedge i_sys_clk);
    bus(2'h2, osc_pkg::STATUS_OFFSET, 8'h00);
    port_hold <= 1'b1;
    idle(8);
    port_hold <= 1'b0;
    bus(2'h2, osc_pkg::CONFIG_OFFSET, 8'h03);
    idle(100);
    bus(2'h2, osc_pkg::STATUS_OFFSET, 8'h02);
    idle(1);
    for (int i = 0; i < 300 && o_internal_osc_running !== 1'b0; i++) @(negedge i_sys_clk);
    if (o_internal_osc_running !== 1'b0) begin
      miscompares++;
      end_sim();
    end
    @(posedge i_sys_clk);
    bus(2'h1, osc_pkg::STATUS_OFFSET, 8'h03);
    bus(2'h2, osc_pkg::STATUS_OFFSET, 8'h00);
    ext_run <= 1'b0;
    idle(50);
    bus(2'h1, osc_pkg::STATUS_OFFSET, 8'h01);
    i_reset <= 1'b1;
    idle(2);
    i_reset <= 1'b0;
    idle(1);
    @(negedge i_sys_clk);
    chk({6'h00, o_internal_osc_running, o_clock_in_pin_is_clock}, 8'h02);
    @(posedge i_sys_clk);
    bus(2'h1, osc_pkg::TRIM_OFFSET, osc_pkg::TRIM_RESET);
    idle(2);
    end_sim();
  end
endmodule : test_osc_clock_source_switch
